// ===== rtl/amse_pkg.sv
// shared constants for the asynchronous memory strobe engine
package amse_pkg;

  // ************************************************************
  // interface clock source selection
  // ************************************************************
  localparam logic [1:0] CLK_SRC_EXT = 2'h0;
  localparam logic [1:0] CLK_SRC_DIV4 = 2'h1;
  localparam logic [1:0] CLK_SRC_DIV6 = 2'h2;
  localparam int CPU_DIV_A = 4;
  localparam int CPU_DIV_B = 6;
  localparam int DIV_CNT_W = 3;

  // ************************************************************
  // divided clock output ratio selection
  // ************************************************************
  localparam logic [1:0] OUT_DIV_1 = 2'h0;
  localparam logic [1:0] OUT_DIV_2 = 2'h1;
  localparam logic [1:0] OUT_DIV_4 = 2'h2;

  // ************************************************************
  // access timing
  // ************************************************************
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] READY_WINDOW = 6'h02;
  localparam logic [CNT_W-1:0] READY_TAIL = 6'h02;

  // ************************************************************
  // access sequencer states
  // ************************************************************
  typedef enum logic [1:0]
  {
    AMSE_IDLE = 2'b00,
    AMSE_SETUP = 2'b01,
    AMSE_STROBE = 2'b10,
    AMSE_HOLD = 2'b11
  } amse_state_t;

endpackage

// ===== rtl/amse_top.sv
// asynchronous memory strobe engine: clock generation and access sequencer
// What this block does
// R01: interface clock from pin, cpu/4 or cpu/6
// R02: divided clock output is input clock /1,/2,/4
// R03: phase lengths counted in interface clock periods
// R04: per-space setup, strobe, hold for reads, writes
// R05: ready input synchronised before any use
// R06: ready looked at only last two strobe cycles
// R07: ready low stretches strobe cycle by cycle
// R08: strobe ends two cycles after ready high
// R09: far side holds ready levels about two periods
// R10: three control pins act as oe, read, write
// R11: enables, address, oe, write data are selects
// R12: connects gluelessly to sram, rom and fifo
// R13: setup, strobe, hold; strobe only in middle
// R14: read data taken at final strobe cycle end
module amse_top
  import amse_pkg::*;
#(
  parameter int NUM_SPACES = 4,
  parameter int SPACE_W = 2,
  parameter int ADDR_W = 20,
  parameter int DATA_W = 64,
  parameter int BE_W = 8,
  parameter int SETUP_W = 4,
  parameter int STROBE_W = 6,
  parameter int HOLD_W = 3
)
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [1:0] CLK_SRC_SEL,
  input wire logic [1:0] CLK_OUT_DIV_SEL,
  input wire logic [NUM_SPACES*SETUP_W-1:0] CFG_READ_SETUP,
  input wire logic [NUM_SPACES*STROBE_W-1:0] CFG_READ_STROBE,
  input wire logic [NUM_SPACES*HOLD_W-1:0] CFG_READ_HOLD,
  input wire logic [NUM_SPACES*SETUP_W-1:0] CFG_WRITE_SETUP,
  input wire logic [NUM_SPACES*STROBE_W-1:0] CFG_WRITE_STROBE,
  input wire logic [NUM_SPACES*HOLD_W-1:0] CFG_WRITE_HOLD,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [SPACE_W-1:0] REQ_SPACE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [BE_W-1:0] REQ_BYTE_EN,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  output logic [DATA_W-1:0] RD_DATA,
  output logic RD_VALID,
  output logic ACCESS_DONE,
  input wire logic MEM_CLOCK_IN,
  output logic MEM_CLOCK_OUT_FULL,
  output logic MEM_CLOCK_OUT_DIVIDED,
  input wire logic EXT_READY_IN,
  output logic [NUM_SPACES-1:0] CHIP_ENABLE_N,
  output logic [BE_W-1:0] BYTE_ENABLE_N,
  output logic [ADDR_W-1:0] MEM_ADDR_BUS,
  output logic [DATA_W-1:0] MEM_DATA_OUT,
  output logic MEM_DATA_OE,
  input wire logic [DATA_W-1:0] MEM_DATA_IN,
  output logic OUTPUT_ENABLE_N,
  output logic READ_STROBE_N,
  output logic WRITE_STROBE_N
);

  // a programmed zero still yields one full interface period
  function automatic logic [CNT_W-1:0] min_one(input logic [CNT_W-1:0] v);
    min_one = (v == '0) ? CNT_W'(1) : v;
  endfunction

  // ************************************************************
  // interface clock generation
  // ************************************************************
  logic [DIV_CNT_W-1:0] div_cnt, next_div_cnt;
  logic ext_s1, ext_s2;
  logic clk_level, next_clk_level;
  logic [1:0] out_cnt, next_out_cnt;
  logic div_out, next_div_out;
  logic tick;
  logic [DIV_CNT_W-1:0] div_top;
  logic [DIV_CNT_W-1:0] div_half;

  // source level picked per select, edge of it becomes the tick enable
  always_comb
  begin
    div_top = (CLK_SRC_SEL == CLK_SRC_DIV6) ? DIV_CNT_W'(CPU_DIV_B - 1)
                                             : DIV_CNT_W'(CPU_DIV_A - 1);
    div_half = (CLK_SRC_SEL == CLK_SRC_DIV6) ? DIV_CNT_W'(CPU_DIV_B / 2)
                                              : DIV_CNT_W'(CPU_DIV_A / 2);
    next_div_cnt = (div_cnt >= div_top) ? '0 : div_cnt + DIV_CNT_W'(1);
    if (CLK_SRC_SEL == CLK_SRC_EXT) // [R01]
    begin
      next_clk_level = ext_s2;
    end
    else
    begin
      next_clk_level = (div_cnt < div_half); // [R01]
    end
    tick = next_clk_level & ~clk_level; // [R03]
    next_out_cnt = tick ? out_cnt + 2'h1 : out_cnt;
    case (CLK_OUT_DIV_SEL) // [R02]
      OUT_DIV_2: next_div_out = out_cnt[0];
      OUT_DIV_4: next_div_out = out_cnt[1];
      default: next_div_out = clk_level;
    endcase
  end

  // pin clock is sampled by two flops; only the second is read
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      div_cnt <= '0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      clk_level <= 1'b0;
      out_cnt <= '0;
      div_out <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      ext_s1 <= MEM_CLOCK_IN;
      ext_s2 <= ext_s1;
      clk_level <= next_clk_level;
      out_cnt <= next_out_cnt;
      div_out <= next_div_out;
    end
  end

  assign MEM_CLOCK_OUT_FULL = clk_level;
  assign MEM_CLOCK_OUT_DIVIDED = div_out;

  // ************************************************************
  // ready and read data synchronisers
  // ************************************************************
  logic rdy_s1, rdy_s2;
  logic [DATA_W-1:0] din_s1, din_s2;

  // ready may toggle at any time, so it never reaches logic unsynchronised
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rdy_s1 <= 1'b1;
      rdy_s2 <= 1'b1;
      din_s1 <= '0;
      din_s2 <= '0;
    end
    else
    begin
      rdy_s1 <= EXT_READY_IN; // [R05]
      rdy_s2 <= rdy_s1; // [R05]
      din_s1 <= MEM_DATA_IN;
      din_s2 <= din_s1;
    end
  end

  // ************************************************************
  // access sequencer
  // ************************************************************
  amse_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] strobe_len, next_strobe_len;
  logic [CNT_W-1:0] hold_len, next_hold_len;
  logic is_write, next_is_write;
  logic rdy_seen_low, next_rdy_seen_low;
  logic [NUM_SPACES-1:0] ce_n, next_ce_n;
  logic [BE_W-1:0] be_n, next_be_n;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic oe_n, next_oe_n, re_n, next_re_n, we_n, next_we_n, dat_oe, next_dat_oe;
  logic rd_valid, next_rd_valid, done, next_done;
  logic [CNT_W-1:0] cfg_setup, cfg_strobe, cfg_hold;
  logic take;

  // requests are taken only on an interface tick so setup is whole periods
  assign REQ_READY = (state == AMSE_IDLE) && tick;
  assign take = REQ_VALID && REQ_READY;

  always_comb
  begin
    // per-space timing pulled from the flat configuration ports
    if (REQ_WRITE)
    begin
      cfg_setup = CNT_W'(CFG_WRITE_SETUP[REQ_SPACE*SETUP_W +: SETUP_W]); // [R04]
      cfg_strobe = CNT_W'(CFG_WRITE_STROBE[REQ_SPACE*STROBE_W +: STROBE_W]); // [R04]
      cfg_hold = CNT_W'(CFG_WRITE_HOLD[REQ_SPACE*HOLD_W +: HOLD_W]); // [R04]
    end
    else
    begin
      cfg_setup = CNT_W'(CFG_READ_SETUP[REQ_SPACE*SETUP_W +: SETUP_W]); // [R04]
      cfg_strobe = CNT_W'(CFG_READ_STROBE[REQ_SPACE*STROBE_W +: STROBE_W]); // [R04]
      cfg_hold = CNT_W'(CFG_READ_HOLD[REQ_SPACE*HOLD_W +: HOLD_W]); // [R04]
    end
    next_state = state;
    next_cnt = cnt;
    next_strobe_len = strobe_len;
    next_hold_len = hold_len;
    next_is_write = is_write;
    next_rdy_seen_low = rdy_seen_low;
    next_ce_n = ce_n;
    next_be_n = be_n;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_oe_n = oe_n;
    next_re_n = re_n;
    next_we_n = we_n;
    next_dat_oe = dat_oe;
    next_rd_valid = 1'b0;
    next_done = 1'b0;
    case (state)
      AMSE_IDLE:
      begin
        if (take)
        begin
          // selects go valid at setup start and stay through hold
          next_state = AMSE_SETUP; // [R13]
          next_cnt = min_one(cfg_setup);
          next_strobe_len = min_one(cfg_strobe);
          next_hold_len = min_one(cfg_hold);
          next_is_write = REQ_WRITE;
          next_rdy_seen_low = 1'b0;
          next_ce_n = ~(NUM_SPACES'(1) << REQ_SPACE); // [R11]
          next_be_n = ~REQ_BYTE_EN; // [R11]
          next_addr = REQ_ADDR; // [R11]
          next_wdata = REQ_WDATA; // [R11]
          next_dat_oe = REQ_WRITE; // [R11]
          next_oe_n = REQ_WRITE; // [R10] [R11]
        end
      end
      AMSE_SETUP:
      begin
        if (tick)
        begin
          if (cnt == CNT_W'(1))
          begin
            next_state = AMSE_STROBE; // [R13]
            next_cnt = strobe_len;
            next_re_n = is_write; // [R10]
            next_we_n = ~is_write; // [R10]
          end
          else
          begin
            next_cnt = cnt - CNT_W'(1); // [R03]
          end
        end
      end
      AMSE_STROBE:
      begin
        if (tick)
        begin
          if (cnt > READY_WINDOW)
          begin
            next_cnt = cnt - CNT_W'(1); // [R06]
          end
          else if (!rdy_s2)
          begin
            next_rdy_seen_low = 1'b1; // [R07]
          end
          else if (rdy_seen_low)
          begin
            // ready back high: exactly two more strobe periods follow
            next_rdy_seen_low = 1'b0;
            next_cnt = READY_TAIL; // [R08]
          end
          else if (cnt == CNT_W'(1))
          begin
            next_state = AMSE_HOLD; // [R13]
            next_cnt = hold_len;
            next_re_n = 1'b1;
            next_we_n = 1'b1;
            next_rdata = is_write ? rdata : din_s2; // [R14]
            next_rd_valid = ~is_write; // [R14]
          end
          else
          begin
            next_cnt = cnt - CNT_W'(1);
          end
        end
      end
      AMSE_HOLD:
      begin
        if (tick)
        begin
          if (cnt == CNT_W'(1))
          begin
            next_state = AMSE_IDLE; // [R13]
            next_ce_n = '1;
            next_be_n = '1;
            next_oe_n = 1'b1;
            next_dat_oe = 1'b0;
            next_done = 1'b1;
          end
          else
          begin
            next_cnt = cnt - CNT_W'(1);
          end
        end
      end
      default:
      begin
        next_state = AMSE_IDLE;
      end
    endcase
  end

  // all memory pins come straight from flops, so no glitches on strobes
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state <= AMSE_IDLE;
      cnt <= '0;
      strobe_len <= '0;
      hold_len <= '0;
      is_write <= 1'b0;
      rdy_seen_low <= 1'b0;
      ce_n <= '1;
      be_n <= '1;
      addr <= '0;
      wdata <= '0;
      rdata <= '0;
      oe_n <= 1'b1;
      re_n <= 1'b1;
      we_n <= 1'b1;
      dat_oe <= 1'b0;
      rd_valid <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      strobe_len <= next_strobe_len;
      hold_len <= next_hold_len;
      is_write <= next_is_write;
      rdy_seen_low <= next_rdy_seen_low;
      ce_n <= next_ce_n;
      be_n <= next_be_n;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      oe_n <= next_oe_n;
      re_n <= next_re_n;
      we_n <= next_we_n;
      dat_oe <= next_dat_oe;
      rd_valid <= next_rd_valid;
      done <= next_done;
    end
  end

  assign CHIP_ENABLE_N = ce_n; // plain flopped pins, no glue to sram, rom or fifo [R12]
  assign BYTE_ENABLE_N = be_n;
  assign MEM_ADDR_BUS = addr;
  assign MEM_DATA_OUT = wdata;
  assign MEM_DATA_OE = dat_oe;
  assign OUTPUT_ENABLE_N = oe_n;
  assign READ_STROBE_N = re_n;
  assign WRITE_STROBE_N = we_n;
  assign RD_DATA = rdata;
  assign RD_VALID = rd_valid;
  assign ACCESS_DONE = done;

endmodule

// ===== sim/amse_top_properties.sv
// concurrent checks on the strobe engine pins
module amse_top_properties
  import amse_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [1:0] CLK_SRC_SEL,
  input wire logic [1:0] CLK_OUT_DIV_SEL,
  input wire logic REQ_READY,
  input wire logic RD_VALID,
  input wire logic ACCESS_DONE,
  input wire logic MEM_CLOCK_OUT_FULL,
  input wire logic MEM_CLOCK_OUT_DIVIDED,
  input wire logic EXT_READY_IN,
  input wire logic [3:0] CHIP_ENABLE_N,
  input wire logic [7:0] BYTE_ENABLE_N,
  input wire logic [19:0] MEM_ADDR_BUS,
  input wire logic MEM_DATA_OE,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N
);
  // ****************************************
  // pin relations, single clock domain
  // ****************************************
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  // cycles since the last rise of the divided clock; zero until a first rise
  logic div_last;
  int div_gap;
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      div_last <= 1'b0;
      div_gap <= 0;
    end
    else
    begin
      div_last <= MEM_CLOCK_OUT_DIVIDED;
      if (MEM_CLOCK_OUT_DIVIDED && !div_last)
        div_gap <= 1;
      else if (div_gap != 0)
        div_gap <= div_gap + 1;
    end
  end
  a_strobe_excl: assert property (READ_STROBE_N || WRITE_STROBE_N)
    else $error("both strobes low");
  a_strobe_sel: assert property (!(READ_STROBE_N && WRITE_STROBE_N) |-> !(&CHIP_ENABLE_N))
    else $error("strobe without chip enable");
  a_oe_read: assert property (!OUTPUT_ENABLE_N |-> !MEM_DATA_OE && WRITE_STROBE_N)
    else $error("output enable during write");
  a_idle_quiet: assert property (REQ_READY |-> (&CHIP_ENABLE_N) && READ_STROBE_N)
    else $error("select active while idle");
  a_select_hold: assert property (!(&CHIP_ENABLE_N) && !(&$past(CHIP_ENABLE_N)) |->
    $stable(MEM_ADDR_BUS) && $stable(BYTE_ENABLE_N) && $stable(CHIP_ENABLE_N))
    else $error("select moved in access");
  a_rdvalid_end: assert property (RD_VALID |-> $rose(READ_STROBE_N))
    else $error("read data not at strobe end");
  a_done_close: assert property (ACCESS_DONE |-> $rose(&CHIP_ENABLE_N) ##1 !ACCESS_DONE)
    else $error("done not at select release");
  a_ready_stretch: assert property ((!READ_STROBE_N && !EXT_READY_IN)[*3] |=> !READ_STROBE_N)
    else $error("strobe ended while not ready");
  a_div4_rate: assert property (CLK_SRC_SEL == CLK_SRC_DIV4 && $rose(MEM_CLOCK_OUT_FULL) |=>
    !$rose(MEM_CLOCK_OUT_FULL)[*3] ##1 $rose(MEM_CLOCK_OUT_FULL))
    else $error("cpu/4 period wrong");
  a_div6_rate: assert property (CLK_SRC_SEL == CLK_SRC_DIV6 && $rose(MEM_CLOCK_OUT_FULL) |=>
    !$rose(MEM_CLOCK_OUT_FULL)[*5] ##1 $rose(MEM_CLOCK_OUT_FULL))
    else $error("cpu/6 period wrong");
  a_out_div2: assert property (CLK_SRC_SEL == CLK_SRC_DIV4 && CLK_OUT_DIV_SEL == OUT_DIV_2
    && $rose(MEM_CLOCK_OUT_DIVIDED) |=> !$rose(MEM_CLOCK_OUT_DIVIDED)[*7]
    ##1 $rose(MEM_CLOCK_OUT_DIVIDED))
    else $error("divided clock period wrong");
  a_out_div4: assert property (CLK_SRC_SEL == CLK_SRC_DIV6 && CLK_OUT_DIV_SEL == OUT_DIV_4
    && MEM_CLOCK_OUT_DIVIDED && !div_last && div_gap != 0 |-> div_gap == CPU_DIV_B * 4)
    else $error("divided clock quarter rate wrong");
  a_out_div1: assert property (CLK_OUT_DIV_SEL == OUT_DIV_1 |->
    MEM_CLOCK_OUT_DIVIDED == $past(MEM_CLOCK_OUT_FULL))
    else $error("divided clock not following full clock");
  c_read: cover property (RD_VALID);
  c_write: cover property ($rose(WRITE_STROBE_N));
  c_stall: cover property ((!READ_STROBE_N && !EXT_READY_IN)[*8]);
endmodule
bind amse_top amse_top_properties chk_u (.REF_CLK(REF_CLK), .RESETN(RESETN),
  .CLK_SRC_SEL(CLK_SRC_SEL), .CLK_OUT_DIV_SEL(CLK_OUT_DIV_SEL), .REQ_READY(REQ_READY),
  .RD_VALID(RD_VALID), .ACCESS_DONE(ACCESS_DONE), .MEM_CLOCK_OUT_FULL(MEM_CLOCK_OUT_FULL),
  .MEM_CLOCK_OUT_DIVIDED(MEM_CLOCK_OUT_DIVIDED), .EXT_READY_IN(EXT_READY_IN),
  .CHIP_ENABLE_N(CHIP_ENABLE_N), .BYTE_ENABLE_N(BYTE_ENABLE_N), .MEM_ADDR_BUS(MEM_ADDR_BUS),
  .MEM_DATA_OE(MEM_DATA_OE), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
  .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N));

// ===== sim/amse_mem_model.sv
// behavioural asynchronous memory with a ready pin
module amse_mem_model
(
  input wire logic clk,
  input wire logic [3:0] ce_n,
  input wire logic [7:0] be_n,
  input wire logic [19:0] addr,
  input wire logic [63:0] wdata,
  input wire logic oe_n,
  input wire logic re_n,
  input wire logic we_n,
  input wire logic [7:0] stall,
  output logic ready,
  output logic [63:0] rdata
);
  // ****************************************
  // storage and pins
  // ****************************************
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] mem [0:15];
  logic [63:0] last = 64'h0;
  logic drive;
  int cnt;
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem[i] = {16{i[3:0]}};
  end
  // bus driven only while selected, else a changing pattern
  assign drive = !oe_n && !(&ce_n);
  assign rdata = drive ? mem[addr[3:0]] : ~last;
  // writes land while the strobe is low, per byte lane
  always @(posedge clk)
  begin
    if (drive)
      last <= mem[addr[3:0]];
    for (int b = 0; b < 8; b++)
      if (!we_n && !(&ce_n) && !be_n[b])
        mem[addr[3:0]][b*8+:8] <= wdata[b*8+:8];
  end
  // not ready for stall cycles from strobe start; bench sets it to 0, 8 or 20
  always @(negedge clk)
  begin
    ready <= (re_n && we_n) || cnt >= stall;
    cnt <= (re_n && we_n) ? 0 : cnt + 1;
  end
endmodule

// ===== sim/async_memory_strobe_engine_bench.sv
// self-checking bench for the strobe engine
module async_memory_strobe_engine_bench
  import amse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, s) \
    begin \
      checks++; \
      if ((s) !== (e)) \
      begin \
        n_mismatch++; \
        $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); \
      end \
    end
  // ****************************************
  // signals, design and memory
  // ****************************************
  typedef struct packed {logic [3:0] ce; logic [15:0] len; logic [15:0] su; logic [15:0] hd;}
    amse_note_t;
  amse_note_t notes[$];
  amse_note_t note;
  logic [63:0] rdq[$];
  logic [63:0] exp_rd;
  bit in_hold = 1'b0;
  logic [63:0] shadow [0:15];
  logic [31:0] seed = 32'h7033;
  int checks = 0, n_mismatch = 0, len = 0, su = 0, hd = 0, div;
  logic clk, rst_n, ext_clk, req_valid, req_ready, req_write, rd_valid, done, full, half;
  logic rdy, doe, oe_n, re_n, we_n;
  logic [1:0] src, odiv, req_space;
  logic [15:0] cfg_rs, cfg_ws;
  logic [23:0] cfg_rst, cfg_wst;
  logic [11:0] cfg_rh, cfg_wh;
  logic [19:0] req_addr, addr;
  logic [7:0] req_be, be_n, stall;
  logic [63:0] req_wdata, rd_data, dout, din;
  logic [3:0] ce_n;
  amse_top dut_u (.REF_CLK(clk), .RESETN(rst_n), .CLK_SRC_SEL(src), .CLK_OUT_DIV_SEL(odiv),
    .CFG_READ_SETUP(cfg_rs), .CFG_READ_STROBE(cfg_rst), .CFG_READ_HOLD(cfg_rh),
    .CFG_WRITE_SETUP(cfg_ws), .CFG_WRITE_STROBE(cfg_wst), .CFG_WRITE_HOLD(cfg_wh),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write),
    .REQ_SPACE(req_space), .REQ_ADDR(req_addr), .REQ_BYTE_EN(req_be), .REQ_WDATA(req_wdata),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .ACCESS_DONE(done), .MEM_CLOCK_IN(ext_clk),
    .MEM_CLOCK_OUT_FULL(full), .MEM_CLOCK_OUT_DIVIDED(half), .EXT_READY_IN(rdy),
    .CHIP_ENABLE_N(ce_n), .BYTE_ENABLE_N(be_n), .MEM_ADDR_BUS(addr), .MEM_DATA_OUT(dout),
    .MEM_DATA_OE(doe), .MEM_DATA_IN(din), .OUTPUT_ENABLE_N(oe_n), .READ_STROBE_N(re_n),
    .WRITE_STROBE_N(we_n));
  amse_mem_model mem_u (.clk(clk), .ce_n(ce_n), .be_n(be_n), .addr(addr), .wdata(dout),
    .oe_n(oe_n), .re_n(re_n), .we_n(we_n), .stall(stall), .ready(rdy), .rdata(din));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // one access; x is the count of ready-stretch periods expected
  task automatic access(input logic wr, input logic [1:0] sp, input logic [3:0] a,
    input logic [7:0] be, input logic [5:0] w, input logic [7:0] st, input int x);
    int n;
    logic [63:0] d;
    int s, h;
    d = {rnd(), rnd()};
    @(negedge clk);
    cfg_rst[sp*6+:6] = w;
    cfg_wst[sp*6+:6] = w;
    stall = st;
    if (!wr)
      rdq.push_back(shadow[a]);
    for (int b = 0; b < 8; b++)
      if (wr && be[b])
        shadow[a][b*8+:8] = d[b*8+:8];
    s = wr ? cfg_ws[sp*4+:4] : cfg_rs[sp*4+:4];
    h = wr ? cfg_wh[sp*3+:3] : cfg_rh[sp*3+:3];
    notes.push_back({~(4'h1 << sp), 16'((((w == 0) ? 1 : w) + x) * div),
      16'(((s == 0) ? 1 : s) * div), 16'(((h == 0) ? 1 : h) * div)});
    {req_write, req_space, req_addr, req_be, req_wdata} = {wr, sp, 16'h0, a, be, d};
    req_valid = 1'b1;
    for (n = 0; n < 50 && req_ready !== 1'b1; n++)
      @(negedge clk);
    // a request never taken or never finished is a hang, so stop here
    if (n == 50)
    begin
      n_mismatch++;
      finish_test();
    end
    @(negedge clk);
    req_valid = 1'b0;
    for (n = 0; n < 600 && done !== 1'b1; n++)
      @(negedge clk);
    if (n == 600)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // setup, strobe and hold widths and chip enable against the notes, read data against rdq
  always @(negedge clk)
  begin
    if (!re_n || !we_n)
      len++;
    else if (!(&ce_n) && len == 0 && !in_hold)
      su++;
    else if (!(&ce_n))
    begin
      if (len > 0)
      begin
        note = notes.pop_front();
        `CHK("strobe length", note.len, 16'(len))
        `CHK("chip enable", note.ce, ce_n)
        `CHK("setup length", note.su, 16'(su))
        len = 0;
        in_hold = 1'b1;
      end
      hd++;
    end
    else if (in_hold)
    begin
      `CHK("hold length", note.hd, 16'(hd))
      su = 0;
      hd = 0;
      in_hold = 1'b0;
    end
    // popped once, so a mismatch report shows the same word that was compared
    if (rd_valid)
    begin
      exp_rd = rdq.pop_front();
      `CHK("read data", exp_rd, rd_data)
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // free pin clock of eight cycles, phase unrelated
  initial
  begin
    ext_clk = 1'b0;
    #7;
    forever #100 ext_clk = ~ext_clk;
  end
  initial
  begin
    #2000000;
    n_mismatch++;
    finish_test();
  end
  // three clock sources, each after its own reset
  initial
  begin
    {rst_n, req_valid, req_write, req_space, req_addr, req_be, req_wdata, stall} = '0;
    {cfg_rst, cfg_wst} = '0;
    for (int i = 0; i < 16; i++)
      shadow[i] = {16{i[3:0]}};
    for (int p = 0; p < 3; p++)
    begin
      rst_n = 1'b0;
      src = (p == 2) ? CLK_SRC_EXT : 2'(p + 1);
      odiv = (p == 0) ? OUT_DIV_2 : (p == 1) ? OUT_DIV_4 : OUT_DIV_1;
      div = (p == 0) ? 4 : (p == 1) ? 6 : 8;
      {cfg_rs, cfg_ws, cfg_rh, cfg_wh} = {rnd(), 24'(rnd())};
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      for (int s = 0; s < 4; s++)
        access(1'b1, 2'(s), 4'(s), 8'hff, 6'(rnd() % 5), 8'h0, 0);
      access(1'b1, 2'h1, 4'h9, 8'h5a, 6'h2, 8'h0, 0);
      for (int s = 0; s < 4; s++)
        access(1'b0, 2'(s), 4'(s), 8'hff, 6'(1 + rnd() % 4), 8'h0, 0);
      access(1'b0, 2'h2, 4'h9, 8'h00, 6'h3, 8'h0, 0);
      if (p == 0)
      begin
        access(1'b0, 2'h3, 4'h2, 8'hff, 6'h2, 8'h14, 6);
        access(1'b1, 2'h0, 4'h5, 8'hff, 6'h2, 8'h14, 6);
        access(1'b0, 2'h1, 4'h5, 8'hff, 6'h6, 8'h08, 0);
      end
    end
    `CHK("notes left", 0, notes.size())
    `CHK("reads left", 0, rdq.size())
    finish_test();
  end
endmodule
